// ---- rtl/sir_pkg.sv ----
// Constants, types and helpers for the sticky interrupt router.
// Assumes one clock domain and an AXI4-Lite register port.
package sir_pkg;

  // ==========================================================
  // Sizes and fixed indices
  localparam int SIR_NSRC     = 24;  // Main sources, at most 32
  localparam int SIR_NMOD     = 8;   // Port-module inputs, at most 32
  localparam int SIR_NDST     = 4;
  localparam int SIR_AW       = 8;
  localparam int SIR_IDX_AGG  = 0;
  localparam int SIR_IDX_EXT0 = 1;
  localparam int SIR_IDX_EXT1 = 2;
  localparam int SIR_DST_EXT0 = 2;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] SIR_OFF_RAW    = 8'h00;
  localparam logic [7:0] SIR_OFF_BYPASS = 8'h04;
  localparam logic [7:0] SIR_OFF_TRIG_L = 8'h08;
  localparam logic [7:0] SIR_OFF_TRIG_H = 8'h0C;
  localparam logic [7:0] SIR_OFF_STICKY = 8'h10;
  localparam logic [7:0] SIR_OFF_ENA    = 8'h14;
  localparam logic [7:0] SIR_OFF_ENACLR = 8'h18;
  localparam logic [7:0] SIR_OFF_ENASET = 8'h1C;
  localparam logic [7:0] SIR_OFF_PEND   = 8'h20;
  localparam logic [7:0] SIR_OFF_MAP0   = 8'h24;
  localparam logic [7:0] SIR_OFF_DPEND0 = 8'h34;
  localparam logic [7:0] SIR_OFF_MPOL   = 8'h44;
  localparam logic [7:0] SIR_OFF_MRAW   = 8'h48;
  localparam logic [7:0] SIR_OFF_MTRIGL = 8'h4C;
  localparam logic [7:0] SIR_OFF_MTRIGH = 8'h50;
  localparam logic [7:0] SIR_OFF_MSTCK  = 8'h54;
  localparam logic [7:0] SIR_OFF_MBYP   = 8'h58;
  localparam logic [7:0] SIR_OFF_MENA   = 8'h5C;
  localparam logic [7:0] SIR_OFF_MPEND  = 8'h60;
  localparam logic [7:0] SIR_OFF_IPOL   = 8'h64;
  localparam logic [7:0] SIR_OFF_OPOL   = 8'h68;
  localparam logic [7:0] SIR_OFF_DRV    = 8'h6C;

  // ==========================================================
  // Reset values and bus answers
  localparam logic [31:0] SIR_RST_CFG     = 32'h00000000;
  localparam logic [31:0] SIR_RST_MOD_POL = 32'hFFFFFFFF;
  localparam logic [1:0]  SIR_RST_EXT_POL = 2'h0;
  localparam logic [1:0]  SIR_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  SIR_RESP_SLVERR = 2'h2;

  // ==========================================================
  // Trigger modes, in field order
  typedef enum logic [1:0] {
    SIR_TRIG_LEVEL,
    SIR_TRIG_ANY,
    SIR_TRIG_FALL,
    SIR_TRIG_RISE
  } sir_trig_e;

  // Set condition of one sticky flag
  function automatic logic sir_detect(input logic [1:0] trig,
                                      input logic       cur,
                                      input logic       prev);
    case (sir_trig_e'(trig))
      SIR_TRIG_LEVEL: sir_detect = cur;
      SIR_TRIG_ANY:   sir_detect = cur ^ prev;
      SIR_TRIG_FALL:  sir_detect = prev & ~cur;
      SIR_TRIG_RISE:  sir_detect = cur & ~prev;
      default:        sir_detect = 1'b0;
    endcase
  endfunction : sir_detect

endpackage : sir_pkg

// ---- rtl/sir_router.sv ----
// Sticky interrupt router: conditioning, latching and routing of sources.
// Assumes sources are synchronous to aclk and an AXI4-Lite master.
//
// Function
// [RQ1] Raw level of every source readable, one bit per source index.
// [RQ2] Level mode: sticky flag set every cycle the source is active.
// [RQ3] Any-edge mode: flag set when source differs from previous cycle.
// [RQ4] Falling-edge mode: flag set on active-to-inactive change.
// [RQ5] Rising-edge mode: flag set on inactive-to-active change.
// [RQ6] Writing 1 clears a sticky flag; writing 0 leaves it.
// [RQ7] A set in the clearing cycle wins over the clear.
// [RQ8] Source forwarded only while flag set and enable bit is 1.
// [RQ9] Readable pending bit: source active and enabled.
// [RQ10] Bypass uses raw value, ignoring sticky flag and trigger.
// [RQ11] Software bypasses only sources already latched at origin.
// [RQ12] Four destinations, each with a per-source mask.
// [RQ13] Destination output is OR of its masked forwarded sources.
// [RQ14] Per destination, readable vector of pending masked sources.
// [RQ15] Module inputs pass a per-module polarity before detection.
// [RQ16] Module inputs have raw, trigger, sticky, bypass, enable, pending.
// [RQ17] Pending module inputs ORed into one main source.
// [RQ18] Two external inputs and two outputs, independent.
// [RQ19] One polarity bit per external input and output line.
// [RQ20] Drive mode 0: output pin driven at both levels.
// [RQ21] Drive mode 1, polarity 0: drive low when asserted, else release.
// [RQ22] Software sets drive mode and polarity before pin enable.
// [RQ23] Internal signals active high; polarity fixed at the edges.
// [RQ24] Aggregate at index 0, external inputs at 1 and 2.
// [RQ25] Destinations 0,1 feed the core; 2,3 the external outputs.
// [RQ26] Write-only aliases clear or set enable bits by writing 1.
// [RQ27] Trigger field 2 bits: level, any, falling, rising.
//
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module sir_router
  import sir_pkg::*;
#(
  parameter int NSRC = SIR_NSRC,
  parameter int NMOD = SIR_NMOD
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write channels
  input  wire logic [SIR_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output wire logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output wire logic              s_axi_wready,
  output wire logic [1:0]        s_axi_bresp,
  output wire logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [SIR_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output wire logic              s_axi_arready,
  output wire logic [31:0]       s_axi_rdata,
  output wire logic [1:0]        s_axi_rresp,
  output wire logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Interrupt sources
  input  wire logic [NSRC-1:3]   periph_irq,
  input  wire logic [NMOD-1:0]   module_irq,
  input  wire logic              external_request_in_0,
  input  wire logic              external_request_in_1,
  // Interrupt destinations
  output wire logic [1:0]        core_irq,
  output wire logic              external_request_out_0,
  output wire logic              external_request_out_0_oe,
  output wire logic              external_request_out_1,
  output wire logic              external_request_out_1_oe
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [NSRC-1:0]             prev;
    logic [NSRC-1:0]             sticky;
    logic [NSRC-1:0]             bypass;
    logic [NSRC-1:0]             ena;
    logic [63:0]                 trig;
    logic [SIR_NDST-1:0][NSRC-1:0] map;
    logic [NMOD-1:0]             mprev;
    logic [NMOD-1:0]             msticky;
    logic [NMOD-1:0]             mbypass;
    logic [NMOD-1:0]             mena;
    logic [NMOD-1:0]             mpol;
    logic [63:0]                 mtrig;
    logic [1:0]                  ipol;
    logic [1:0]                  opol;
    logic [1:0]                  drv;
    logic [1:0]                  cpu;
    logic [1:0]                  xout;
    logic [1:0]                  xoe;
    logic                        aw_full;
    logic                        w_full;
    logic [SIR_AW-1:0]           waddr;
    logic [31:0]                 wdata;
    logic [3:0]                  wstrb;
    logic                        awready;
    logic                        wready;
    logic                        bvalid;
    logic [1:0]                  bresp;
    logic                        arready;
    logic                        rvalid;
    logic [1:0]                  rresp;
    logic [31:0]                 rdata;
  } sir_state_s;

  sir_state_s st_reg;
  sir_state_s st_next;

  logic [NSRC-1:0]               raw;
  logic [NSRC-1:0]               sset;
  logic [NSRC-1:0]               fwd;
  logic [NSRC-1:0]               pend;
  logic [NMOD-1:0]               mraw;
  logic [NMOD-1:0]               mset;
  logic [NMOD-1:0]               mpend;
  logic [SIR_NDST-1:0][NSRC-1:0] dpend;
  logic                          do_write;

  // ==========================================================
  // Source conditioning
  // Polarity applied on entry, all later logic active high
  assign mraw = module_irq ^ ~st_reg.mpol;                  // [RQ15] [RQ23]
  assign mpend = (st_reg.mbypass & mraw |
                  ~st_reg.mbypass & st_reg.msticky) & st_reg.mena; // [RQ16]
  assign raw[SIR_IDX_AGG] = |mpend;                         // [RQ17] [RQ24]
  assign raw[SIR_IDX_EXT0] =
    external_request_in_0 ^ ~st_reg.ipol[0];                // [RQ19] [RQ24]
  assign raw[SIR_IDX_EXT1] =
    external_request_in_1 ^ ~st_reg.ipol[1];                // [RQ18] [RQ24]
  assign raw[NSRC-1:3] = periph_irq;

  // Per-source detection and forwarding
  genvar k;
  for (k = 0; k < NSRC; k++)
  begin : g_src
    assign sset[k] = sir_detect(st_reg.trig[2*k +: 2], raw[k],
                                st_reg.prev[k]);     // [RQ2] [RQ3] [RQ27]
    assign fwd[k] = st_reg.bypass[k] ? raw[k]
                                     : st_reg.sticky[k]; // [RQ10]
  end

  // Per-module detection, same scheme as the main sources
  for (k = 0; k < NMOD; k++)
  begin : g_mod
    assign mset[k] = sir_detect(st_reg.mtrig[2*k +: 2], mraw[k],
                                st_reg.mprev[k]);    // [RQ16] [RQ4] [RQ5]
  end

  // Enabled sources, then per-destination selection
  assign pend = fwd & st_reg.ena;                           // [RQ8] [RQ9]
  for (k = 0; k < SIR_NDST; k++)
  begin : g_dst
    assign dpend[k] = pend & st_reg.map[k];                 // [RQ12] [RQ14]
  end

  assign do_write = st_reg.aw_full && st_reg.w_full && !st_reg.bvalid;

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    logic [31:0]     wm;
    logic [31:0]     wd;
    logic [NSRC-1:0] clr;
    logic [NMOD-1:0] mclr;
    logic [31:0]     rd;
    logic            hit;
    logic            whit;
    st_next = st_reg;
    wm = {{8{st_reg.wstrb[3]}}, {8{st_reg.wstrb[2]}},
          {8{st_reg.wstrb[1]}}, {8{st_reg.wstrb[0]}}};
    wd = st_reg.wdata & wm;
    clr = '0;
    mclr = '0;
    rd = '0;
    hit = 1'b0;
    whit = 1'b1;
    // Register writes once address and data are both held
    if (do_write)
    begin
      case (st_reg.waddr)
        SIR_OFF_BYPASS: st_next.bypass =
          (st_reg.bypass & ~wm[NSRC-1:0]) | wd[NSRC-1:0];
        SIR_OFF_TRIG_L: st_next.trig[31:0] =
          (st_reg.trig[31:0] & ~wm) | wd;
        SIR_OFF_TRIG_H: st_next.trig[63:32] =
          (st_reg.trig[63:32] & ~wm) | wd;
        SIR_OFF_STICKY: clr = wd[NSRC-1:0];                 // [RQ6]
        SIR_OFF_ENA: st_next.ena =
          (st_reg.ena & ~wm[NSRC-1:0]) | wd[NSRC-1:0];
        SIR_OFF_ENACLR: st_next.ena = st_reg.ena & ~wd[NSRC-1:0]; // [RQ26]
        SIR_OFF_ENASET: st_next.ena = st_reg.ena | wd[NSRC-1:0];  // [RQ26]
        SIR_OFF_MPOL: st_next.mpol =
          (st_reg.mpol & ~wm[NMOD-1:0]) | wd[NMOD-1:0];
        SIR_OFF_MTRIGL: st_next.mtrig[31:0] =
          (st_reg.mtrig[31:0] & ~wm) | wd;
        SIR_OFF_MTRIGH: st_next.mtrig[63:32] =
          (st_reg.mtrig[63:32] & ~wm) | wd;
        SIR_OFF_MSTCK: mclr = wd[NMOD-1:0];                 // [RQ16]
        SIR_OFF_MBYP: st_next.mbypass =
          (st_reg.mbypass & ~wm[NMOD-1:0]) | wd[NMOD-1:0];
        SIR_OFF_MENA: st_next.mena =
          (st_reg.mena & ~wm[NMOD-1:0]) | wd[NMOD-1:0];
        SIR_OFF_IPOL: st_next.ipol = (st_reg.ipol & ~wm[1:0]) | wd[1:0];
        SIR_OFF_OPOL: st_next.opol = (st_reg.opol & ~wm[1:0]) | wd[1:0];
        SIR_OFF_DRV: st_next.drv = (st_reg.drv & ~wm[1:0]) | wd[1:0];
        SIR_OFF_RAW, SIR_OFF_PEND, SIR_OFF_MRAW, SIR_OFF_MPEND: whit = 1'b1;
        default: whit = 1'b0;
      endcase
      // Mask registers and read-only destination views
      for (int d = 0; d < SIR_NDST; d++)
      begin
        if (st_reg.waddr == SIR_OFF_MAP0 + 8'(4 * d))
        begin
          st_next.map[d] = (st_reg.map[d] & ~wm[NSRC-1:0]) | wd[NSRC-1:0];
          whit = 1'b1;
        end
        if (st_reg.waddr == SIR_OFF_DPEND0 + 8'(4 * d))
        begin
          whit = 1'b1;
        end
      end
      st_next.aw_full = 1'b0;
      st_next.w_full = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = whit ? SIR_RESP_OKAY : SIR_RESP_SLVERR;
    end
    // Sticky flags: a set in the clearing cycle wins
    st_next.sticky = (st_reg.sticky & ~clr) | sset;        // [RQ7] [RQ2]
    st_next.msticky = (st_reg.msticky & ~mclr) | mset;      // [RQ16] [RQ7]
    st_next.prev = raw;
    st_next.mprev = mraw;
    // Destination outputs; external polarity applied on exit
    for (int d = 0; d < 2; d++)
    begin
      st_next.cpu[d] = |dpend[d];                           // [RQ13] [RQ25]
      st_next.xout[d] = |dpend[SIR_DST_EXT0 + d] ^ ~st_reg.opol[d]; // [RQ19]
      st_next.xoe[d] = st_reg.drv[d] ? |dpend[SIR_DST_EXT0 + d]
                                     : 1'b1;                // [RQ20] [RQ21]
    end
    // Write address and data captured in either order
    if (s_axi_awvalid && st_reg.awready)
    begin
      st_next.aw_full = 1'b1;
      st_next.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_reg.wready)
    begin
      st_next.w_full = 1'b1;
      st_next.wdata = s_axi_wdata;
      st_next.wstrb = s_axi_wstrb;
    end
    if (st_reg.bvalid && s_axi_bready)
    begin
      st_next.bvalid = 1'b0;
    end
    st_next.awready = !st_next.aw_full && !st_next.bvalid;
    st_next.wready = !st_next.w_full && !st_next.bvalid;
    // Read decode
    hit = 1'b1;
    case (s_axi_araddr)
      SIR_OFF_RAW:    rd = 32'(raw);                        // [RQ1]
      SIR_OFF_BYPASS: rd = 32'(st_reg.bypass);
      SIR_OFF_TRIG_L: rd = st_reg.trig[31:0];
      SIR_OFF_TRIG_H: rd = st_reg.trig[63:32];
      SIR_OFF_STICKY: rd = 32'(st_reg.sticky);
      SIR_OFF_ENA:    rd = 32'(st_reg.ena);
      SIR_OFF_PEND:   rd = 32'(pend);                       // [RQ9]
      SIR_OFF_MPOL:   rd = 32'(st_reg.mpol);
      SIR_OFF_MRAW:   rd = 32'(mraw);                       // [RQ16]
      SIR_OFF_MTRIGL: rd = st_reg.mtrig[31:0];
      SIR_OFF_MTRIGH: rd = st_reg.mtrig[63:32];
      SIR_OFF_MSTCK:  rd = 32'(st_reg.msticky);
      SIR_OFF_MBYP:   rd = 32'(st_reg.mbypass);
      SIR_OFF_MENA:   rd = 32'(st_reg.mena);
      SIR_OFF_MPEND:  rd = 32'(mpend);                      // [RQ16]
      SIR_OFF_IPOL:   rd = 32'(st_reg.ipol);
      SIR_OFF_OPOL:   rd = 32'(st_reg.opol);
      SIR_OFF_DRV:    rd = 32'(st_reg.drv);
      SIR_OFF_ENACLR, SIR_OFF_ENASET: rd = '0;
      default:        hit = 1'b0;
    endcase
    for (int d = 0; d < SIR_NDST; d++)
    begin
      if (s_axi_araddr == SIR_OFF_MAP0 + 8'(4 * d))
      begin
        rd = 32'(st_reg.map[d]);
        hit = 1'b1;
      end
      if (s_axi_araddr == SIR_OFF_DPEND0 + 8'(4 * d))
      begin
        rd = 32'(dpend[d]);                                 // [RQ14]
        hit = 1'b1;
      end
    end
    if (s_axi_arvalid && st_reg.arready)
    begin
      st_next.rvalid = 1'b1;
      st_next.rdata = rd;
      st_next.rresp = hit ? SIR_RESP_OKAY : SIR_RESP_SLVERR;
    end
    else if (st_reg.rvalid && s_axi_rready)
    begin
      st_next.rvalid = 1'b0;
    end
    st_next.arready = !st_next.rvalid;
  end

  // State register with synchronous reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_reg <= '0;
      st_reg.mpol <= SIR_RST_MOD_POL[NMOD-1:0];
      st_reg.ipol <= SIR_RST_EXT_POL;
      st_reg.opol <= SIR_RST_EXT_POL;
      st_reg.trig <= {SIR_RST_CFG, SIR_RST_CFG};
      st_reg.xout <= ~SIR_RST_EXT_POL;
      st_reg.xoe <= 2'h3;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Outputs, all from the state register
  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready = st_reg.wready;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign core_irq = st_reg.cpu;
  assign external_request_out_0 = st_reg.xout[0];
  assign external_request_out_1 = st_reg.xout[1];
  assign external_request_out_0_oe = st_reg.xoe[0];
  assign external_request_out_1_oe = st_reg.xoe[1];

  // ==========================================================
  // Checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  logic [1:0] trig1;
  assign trig1 = st_reg.trig[3:2];

  sequence s_od_cfg;
    st_reg.drv[0] && !st_reg.opol[0];
  endsequence

  sequence s_dst2_req;
    |dpend[SIR_DST_EXT0];
  endsequence

  a_level_hold: assert property ( // [RQ2]
    (trig1 == SIR_TRIG_LEVEL && raw[1]) |=> st_reg.sticky[1])
    else $error("level source did not keep sticky set");
  a_any_edge: assert property ( // [RQ3]
    (trig1 == SIR_TRIG_ANY && $changed(raw[1]) && st_reg.prev[1] != raw[1])
    |=> st_reg.sticky[1])
    else $error("any edge missed");
  a_fall_edge: assert property ( // [RQ4]
    (trig1 == SIR_TRIG_FALL && st_reg.prev[1] && !raw[1])
    |=> st_reg.sticky[1])
    else $error("falling edge missed");
  a_rise_edge: assert property ( // [RQ5]
    (trig1 == SIR_TRIG_RISE && !st_reg.prev[1] && raw[1])
    |=> st_reg.sticky[1])
    else $error("rising edge missed");
  a_w1c_clear: assert property ( // [RQ6]
    (do_write && st_reg.waddr == SIR_OFF_STICKY && st_reg.wstrb[0] &&
     st_reg.wdata[1] && !sset[1]) |=> !st_reg.sticky[1])
    else $error("write one did not clear sticky");
  a_set_wins: assert property ( // [RQ7]
    (do_write && st_reg.waddr == SIR_OFF_STICKY && sset[1])
    |=> st_reg.sticky[1])
    else $error("clear won over set");
  a_core_out: assert property ( // [RQ13]
    (|(pend & st_reg.map[0])) |=> core_irq[0])
    else $error("core output not asserted");
  a_agg_source: assert property ( // [RQ17]
    (|(st_reg.msticky & st_reg.mena & ~st_reg.mbypass)) |-> raw[0])
    else $error("module aggregate not raised");
  a_od_drive: assert property ( // [RQ21]
    (s_od_cfg ##0 s_dst2_req) |=>
    (external_request_out_0_oe && !external_request_out_0))
    else $error("open collector not driving low");
  a_od_release: assert property ( // [RQ21]
    (s_od_cfg ##0 !(|dpend[SIR_DST_EXT0])) |=> !external_request_out_0_oe)
    else $error("open collector not released");
  a_push_pull: assert property ( // [RQ20]
    !st_reg.drv[1] |=> external_request_out_1_oe)
    else $error("push-pull output released");

endmodule : sir_router

`default_nettype wire

// ---- test/sir_router_tb_top.sv ----
// Self-checking bench for the sticky interrupt router.
// Assumes sir_pkg, sir_router and the source model sir_src_model.
`timescale 1ns/1ps
`default_nettype none
module sir_router_tb_top;
  import sir_pkg::*;
  // ==========================================================
  // Clock, reset, bus and source wishes
  logic                aclk     = 1'b0;
  logic                aresetn  = 1'b0;
  logic [7:0]          awaddr   = 8'h00;
  logic [7:0]          araddr   = 8'h00;
  logic [31:0]         wdata    = 32'h0;
  logic [3:0]          wstrb    = 4'hF;
  logic                awvalid  = 1'b0;
  logic                wvalid   = 1'b0;
  logic                bready   = 1'b0;
  logic                arvalid  = 1'b0;
  logic                rready   = 1'b0;
  logic                awready, wready, bvalid, arready, rvalid;
  logic [1:0]          bresp, rresp, core_irq, pin_out, pin_oe;
  logic [1:0]          wire_lvl, ext_in, last_resp;
  logic [31:0]         rdata, d;
  logic [SIR_NSRC-1:3] per;
  logic [SIR_NSRC-1:3] want_per = '0;
  logic [SIR_NMOD-1:0] mods;
  logic [SIR_NMOD-1:0] want_mod = '0;
  logic [1:0]          want_ext = 2'h3;
  logic [31:0]         seed     = 32'h0A76;
  int                  n_fail   = 0;
  int                  n_checks = 0;

  always #50 aclk = ~aclk;

  // ==========================================================
  // Router and source model
  sir_router dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .periph_irq(per), .module_irq(mods),
    .external_request_in_0(ext_in[0]), .external_request_in_1(ext_in[1]),
    .core_irq(core_irq), .external_request_out_0(pin_out[0]),
    .external_request_out_0_oe(pin_oe[0]),
    .external_request_out_1(pin_out[1]),
    .external_request_out_1_oe(pin_oe[1]));
  sir_src_model src_u (
    .aclk(aclk), .want_per(want_per), .want_mod(want_mod),
    .want_ext(want_ext), .periph_irq(per), .module_irq(mods),
    .ext_in(ext_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .wire_lvl(wire_lvl));

  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    xs = x ^ (x << 5);
  endfunction : xs
  // Raw view: externals after polarity, aggregate idle
  function automatic logic [31:0] exp_raw(input logic [31:0] s,
                                          input logic        hi);
    exp_raw = 32'({s[SIR_NSRC-1:3], hi ? s[1:0] : ~s[1:0], 1'b0});
  endfunction : exp_raw
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      aw_ok = aw_ok | awready;
      w_ok = w_ok | wready;
    end
    do @(posedge aclk); while (!bvalid);
    last_resp = bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    v = rdata;
    last_resp = rresp;
  endtask : rd
  task automatic settle();
    repeat (3) @(posedge aclk);
  endtask : settle
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test

  // ==========================================================
  // Hang guard
  initial
  begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    end_of_test();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(32'({core_irq, pin_out, pin_oe}), 32'h0F);
    rd(SIR_OFF_ENA, d);
    chk(d, 32'h0);
    rd(8'hFC, d);
    chk({d[29:0], last_resp}, 32'(SIR_RESP_SLVERR));
    wr(8'hF8, 32'hFFFF_FFFF);
    chk(32'(last_resp), 32'(SIR_RESP_SLVERR));
    $display("test reset done");
    // Random levels, then external inputs switched to active high
    for (int i = 0; i < 8; i++)
    begin
      seed = xs(seed);
      if (i == 4) wr(SIR_OFF_IPOL, 32'h3);
      want_per <= seed[SIR_NSRC-1:3];
      want_ext <= seed[1:0];
      settle();
      rd(SIR_OFF_RAW, d);
      chk(d, exp_raw(seed, i >= 4));
    end
    want_per <= '0;
    want_ext <= 2'h0;
    $display("test raw done");
    // Every detect mode on source 3
    for (int m = 0; m < 4; m++)
    begin
      wr(SIR_OFF_TRIG_L, 32'h44 * 32'(m));
      wr(SIR_OFF_STICKY, 32'hFFFF_FFFF);
      want_per[3] <= 1'b1;
      want_ext[0] <= 1'b1;
      settle();
      rd(SIR_OFF_STICKY, d);
      chk(32'(d[3]), 32'(m != 2));
      wr(SIR_OFF_STICKY, 32'h8);
      rd(SIR_OFF_STICKY, d);
      chk(32'(d[3]), 32'(m == 0));
      want_per[3] <= 1'b0;
      want_ext[0] <= 1'b0;
      settle();
      rd(SIR_OFF_STICKY, d);
      chk(32'(d[3]), 32'(m != 3));
    end
    wr(SIR_OFF_TRIG_L, 32'h0);
    $display("test detect done");
    // Routing to core and open-collector output
    want_per[3] <= 1'b1;
    wr(SIR_OFF_DRV, 32'h1);
    wr(SIR_OFF_MAP0, 32'h8);
    wr(SIR_OFF_MAP0 + 8'h08, 32'h8);
    wr(SIR_OFF_ENASET, 32'h8);
    settle();
    chk(32'({core_irq, pin_out, pin_oe, wire_lvl}), 32'h6E);
    rd(SIR_OFF_PEND, d);
    chk(d, 32'h8);
    rd(SIR_OFF_DPEND0, d);
    chk(d, 32'h8);
    rd(SIR_OFF_DPEND0 + 8'h04, d);
    chk(d, 32'h0);
    wr(SIR_OFF_ENACLR, 32'h8);
    settle();
    chk(32'({core_irq, pin_oe, wire_lvl}), 32'h0B);
    rd(SIR_OFF_ENA, d);
    chk(d, 32'h0);
    $display("test route done");
    // Bypass follows the raw level while the flag stays set
    wr(SIR_OFF_BYPASS, 32'h8);
    wr(SIR_OFF_MAP0 + 8'h04, 32'h8);
    wr(SIR_OFF_ENASET, 32'h8);
    want_per[3] <= 1'b0;
    settle();
    chk(32'(core_irq), 32'h0);
    want_per[3] <= 1'b1;
    settle();
    chk(32'(core_irq), 32'h3);
    wr(SIR_OFF_BYPASS, 32'h0);
    wr(SIR_OFF_ENACLR, 32'h8);
    $display("test bypass done");
    // Module input 0 active low, others active high
    wr(SIR_OFF_MPOL, 32'hFE);
    wr(SIR_OFF_MENA, 32'h1);
    want_mod <= 8'hFE;
    settle();
    rd(SIR_OFF_MRAW, d);
    chk(d, 32'hFF);
    rd(SIR_OFF_MPEND, d);
    chk(d, 32'h1);
    rd(SIR_OFF_RAW, d);
    chk(32'(d[0]), 32'h1);
    wr(SIR_OFF_MTRIGL, 32'h3);
    wr(SIR_OFF_MSTCK, 32'h1);
    rd(SIR_OFF_MPEND, d);
    chk(d, 32'h0);
    $display("test module done");
    end_of_test();
  end
endmodule : sir_router_tb_top
`default_nettype wire

// ---- test/sir_src_model.sv ----
// Source model: peripheral, module and external request lines.
// Assumes the bench sets wanted levels; pins change after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module sir_src_model
  import sir_pkg::*;
(
  // Clock and wanted levels
  input  wire logic                aclk,
  input  wire logic [SIR_NSRC-1:3] want_per,
  input  wire logic [SIR_NMOD-1:0] want_mod,
  input  wire logic [1:0]          want_ext,
  // Lines into the router
  output logic      [SIR_NSRC-1:3] periph_irq,
  output logic      [SIR_NMOD-1:0] module_irq,
  output logic      [1:0]          ext_in,
  // Output pins and the wires they reach
  input  wire logic [1:0]          pin_out,
  input  wire logic [1:0]          pin_oe,
  output wire logic [1:0]          wire_lvl
);
  // ==========================================================
  // Levels launched at each rising edge, held steady between wishes
  always @(posedge aclk)
  begin
    periph_irq <= want_per;
    module_irq <= want_mod;
    ext_in     <= want_ext;
  end
  // Pull-up wins when no driver holds the wire
  assign wire_lvl = (pin_oe & pin_out) | ~pin_oe;
endmodule : sir_src_model
`default_nettype wire
